// ---- hfq_pkg.sv ----
// Shared constants and types for the host frame queue access block
package hfq_pkg;

    // Register offsets seen through the host address cycle
    localparam logic [10:0] TXQ_CMD_OFFSET   = 11'h180;
    localparam logic [10:0] QUEUE_CMD_OFFSET = 11'h182;
    localparam logic [10:0] TX_PTR_OFFSET    = 11'h184;

    // Address cycle layout on the data pins
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W   = 11;
    localparam int BE_LSB   = 12;
    localparam int BE_W     = 4;

    // Queue command register fields
    localparam int QC_RELEASE_BIT   = 0;
    localparam int QC_START_DMA_BIT = 3;
    localparam int QC_AUTO_DEQ_BIT  = 4;
    localparam int QC_FRAME_THR_BIT = 5;
    localparam int QC_BYTE_THR_BIT  = 6;
    localparam int QC_FRAME_STS_BIT = 10;
    localparam int QC_BYTE_STS_BIT  = 11;

    // Transmit pointer register fields
    localparam int              TP_AUTO_INC_BIT = 14;
    localparam int              TP_PTR_W        = 11;
    localparam logic [10:0]     TP_PTR_RESET    = 11'h000;

    // Transmit queue command register field
    localparam int TQ_ENQUEUE_BIT = 0;

    // Pointer steps per access size
    localparam logic [10:0] STEP_BYTE  = 11'h001;
    localparam logic [10:0] STEP_WORD  = 11'h002;
    localparam logic [10:0] STEP_DWORD = 11'h004;

    // Control reset values and the all-lanes byte enable
    localparam logic       CTRL_RESET = 1'b0;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [3:0]  BE_RESET   = 4'h0;
    localparam logic [3:0]  BE_ALL     = 4'hF;

    // Host bus events after synchronisation
    typedef struct packed {
        logic        wr_done;
        logic        rd_start;
        logic        rd_end;
        logic        cmd;
        logic [15:0] wdata;
    } bus_evt_s;

    // One write into the transmit queue
    typedef struct packed {
        logic [10:0] ptr;
        logic [3:0]  be;
        logic [15:0] data;
    } txq_write_s;

    // Read path state
    typedef enum logic [2:0] {
        RD_IDLE  = 3'b001,
        RD_REG   = 3'b010,
        RD_QUEUE = 3'b100
    } rd_state_e;

endpackage

// ---- host_bus_sync.sv ----
// Host bus pin synchroniser and strobe edge detector
`timescale 1ns/1ps
module host_bus_sync (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_chip_select_n,
    input  wire logic             i_read_strobe_n,
    input  wire logic             i_write_strobe_n,
    input  wire logic             i_cmd,
    input  wire logic [15:0]      i_data,
    output hfq_pkg::bus_evt_s     o_evt
);

    logic [19:0] meta_r;
    logic [19:0] sync_r;
    logic [1:0]  prev_r;
    logic [15:0] wdata_r;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;

    // Two stages on every pin; first stage feeds only the second
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= 20'hF_FFFF;
            sync_r <= 20'hF_FFFF;
        end else begin
            meta_r <= {i_chip_select_n, i_read_strobe_n, i_write_strobe_n, i_cmd, i_data};
            sync_r <= meta_r;
        end
    end

    assign cs_n = sync_r[19];
    assign rd_n = sync_r[18] | cs_n;
    assign wr_n = sync_r[17] | cs_n;

    // Previous strobes, and data sampled every cycle while the write strobe is low
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_r  <= 2'h3;
            wdata_r <= hfq_pkg::DATA_RESET;
        end else begin
            prev_r <= {rd_n, wr_n};
            if (!wr_n) begin
                wdata_r <= sync_r[15:0];
            end
        end
    end

    // Write commits at strobe release so data is settled
    assign o_evt.wr_done  = !prev_r[0] && wr_n;
    assign o_evt.rd_start = prev_r[1] && !rd_n;
    assign o_evt.rd_end   = !prev_r[1] && rd_n;
    assign o_evt.cmd      = sync_r[16];
    assign o_evt.wdata    = wdata_r;

endmodule

// ---- host_frame_queue_access.sv ----
// Host access to the receive and transmit frame queues
//
// Function
// - With the byte threshold enable set, raise the receive interrupt when queued bytes pass the byte threshold.
// - With the frame threshold enable set, raise the receive interrupt when queued frames pass the frame threshold.
// - With auto dequeue on, move the receive read position to the next frame once the host has read the current one.
// - While start-DMA is set, data accesses with the command pin low go to the queue buffers, except at the queue command register.
// - While a queue DMA is active, only the queue command register can be reached as a register.
// - Writing one to the release bit frees the memory of the current erroneous receive frame.
// - The release bit clears itself once the memory is freed, and the host waits for it.
// - With auto increment set, each host write to frame data advances the transmit pointer.
// - The pointer step is one for a byte, two for a word and four for a double word access.
// - With auto increment clear, data accesses leave the transmit pointer unchanged.
// - The transmit pointer is an 11-bit read-only field in the low bits that resets to zero.
// - After a transmit enqueue the pointer loads the next free transmit frame location.
// - Writing one to the enqueue bit queues the frame; it clears itself when sending is done.
`timescale 1ns/1ps
module host_frame_queue_access (
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_read_strobe_n,
    input  wire logic              i_write_strobe_n,
    input  wire logic              i_cmd,
    input  wire logic [15:0]       i_data,
    output logic      [15:0]       o_data,
    output logic                   o_data_oe_n,
    input  wire logic [15:0]       i_rx_byte_count,
    input  wire logic [15:0]       i_rx_byte_threshold_value,
    input  wire logic [7:0]        i_rx_frame_count,
    input  wire logic [7:0]        i_rx_frame_threshold_value,
    output logic                   o_rx_threshold_irq,
    input  wire logic              i_rx_frame_read_done,
    output logic                   o_rx_dequeue,
    output logic                   o_rxq_read,
    input  wire logic [15:0]       i_rxq_data,
    input  wire logic              i_rx_release_done,
    output logic                   o_rx_release_req,
    output logic                   o_txq_write,
    output hfq_pkg::txq_write_s    o_txq_word,
    input  wire logic              i_tx_enqueued,
    input  wire logic [10:0]       i_tx_next_free,
    input  wire logic              i_tx_sent,
    output logic                   o_tx_enqueue_req,
    output logic                   o_start_dma
);

    hfq_pkg::bus_evt_s  evt;
    hfq_pkg::rd_state_e rd_state_r;
    hfq_pkg::rd_state_e rd_state_nxt;

    logic [10:0] addr_r;
    logic [3:0]  be_r;
    logic        byte_thr_en_r;
    logic        frame_thr_en_r;
    logic        auto_deq_r;
    logic        start_dma_r;
    logic        release_r;
    logic        byte_hit_r;
    logic        frame_hit_r;
    logic        auto_inc_r;
    logic [10:0] tx_ptr_r;
    logic        enqueue_r;
    logic        lane_lo;
    logic        lane_hi;
    logic        queue_path;
    logic        data_cycle;
    logic        reg_wr;
    logic        q_wr;
    logic [10:0] step;
    logic [15:0] reg_rdata;

    // Pins pass two flip-flops before any logic reads them
    host_bus_sync u_sync (
        .i_clk            (i_clk),
        .i_nrst           (i_nrst),
        .i_chip_select_n  (i_chip_select_n),
        .i_read_strobe_n  (i_read_strobe_n),
        .i_write_strobe_n (i_write_strobe_n),
        .i_cmd            (i_cmd),
        .i_data           (i_data),
        .o_evt            (evt)
    );

    // Address cycle: command pin high latches address and byte enables
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_r <= 11'h000;
            be_r   <= hfq_pkg::BE_RESET;
        end else if (evt.wr_done && evt.cmd) begin
            addr_r <= evt.wdata[hfq_pkg::ADDR_LSB +: hfq_pkg::ADDR_W];
            be_r   <= evt.wdata[hfq_pkg::BE_LSB +: hfq_pkg::BE_W];
        end
    end

    // Lanes follow the word half that the address selects
    assign lane_lo = addr_r[1] ? be_r[2] : be_r[0];
    assign lane_hi = addr_r[1] ? be_r[3] : be_r[1];

    assign data_cycle = !evt.cmd;
    assign queue_path = start_dma_r && (addr_r != hfq_pkg::QUEUE_CMD_OFFSET);
    assign reg_wr     = evt.wr_done && data_cycle && !queue_path;
    assign q_wr       = evt.wr_done && data_cycle && queue_path;

    // Queue command control bits, low byte only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            byte_thr_en_r  <= hfq_pkg::CTRL_RESET;
            frame_thr_en_r <= hfq_pkg::CTRL_RESET;
            auto_deq_r     <= hfq_pkg::CTRL_RESET;
            start_dma_r    <= hfq_pkg::CTRL_RESET;
        end else if (reg_wr && lane_lo && addr_r == hfq_pkg::QUEUE_CMD_OFFSET) begin
            byte_thr_en_r  <= evt.wdata[hfq_pkg::QC_BYTE_THR_BIT];
            frame_thr_en_r <= evt.wdata[hfq_pkg::QC_FRAME_THR_BIT];
            auto_deq_r     <= evt.wdata[hfq_pkg::QC_AUTO_DEQ_BIT];
            // host clears this to leave DMA
            start_dma_r    <= evt.wdata[hfq_pkg::QC_START_DMA_BIT];
        end
    end

    // Release request: host sets, free-done clears; a new set wins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            release_r <= hfq_pkg::CTRL_RESET;
        end else if (reg_wr && lane_lo && addr_r == hfq_pkg::QUEUE_CMD_OFFSET
                     && evt.wdata[hfq_pkg::QC_RELEASE_BIT]) begin
            release_r <= 1'b1;
        end else if (i_rx_release_done) begin
            release_r <= 1'b0;
        end
    end

    // Threshold compare is registered to keep the count paths short
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            byte_hit_r  <= hfq_pkg::CTRL_RESET;
            frame_hit_r <= hfq_pkg::CTRL_RESET;
        end else begin
            byte_hit_r  <= byte_thr_en_r && (i_rx_byte_count > i_rx_byte_threshold_value);
            frame_hit_r <= frame_thr_en_r && (i_rx_frame_count > i_rx_frame_threshold_value);
        end
    end

    // Interrupt level towards the status register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_threshold_irq <= hfq_pkg::CTRL_RESET;
        end else begin
            o_rx_threshold_irq <= byte_hit_r || frame_hit_r;
        end
    end

    // Dequeue pulse towards the receive queue manager
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_dequeue <= hfq_pkg::CTRL_RESET;
        end else begin
            o_rx_dequeue <= auto_deq_r && i_rx_frame_read_done;
        end
    end

    // Transmit pointer auto increment, high byte of the pointer register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            auto_inc_r <= hfq_pkg::CTRL_RESET;
        end else if (reg_wr && lane_hi && addr_r == hfq_pkg::TX_PTR_OFFSET) begin
            auto_inc_r <= evt.wdata[hfq_pkg::TP_AUTO_INC_BIT];
        end
    end

    always_comb begin
        if (be_r == hfq_pkg::BE_ALL) begin
            step = hfq_pkg::STEP_DWORD;
        end else if (lane_lo && lane_hi) begin
            step = hfq_pkg::STEP_WORD;
        end else begin
            step = hfq_pkg::STEP_BYTE;
        end
    end

    // Pointer: enqueue reload beats a same-cycle increment
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_ptr_r <= hfq_pkg::TP_PTR_RESET;
        end else if (i_tx_enqueued) begin
            tx_ptr_r <= i_tx_next_free;
        end else if (q_wr && auto_inc_r) begin
            tx_ptr_r <= tx_ptr_r + step;
        end
    end

    // Enqueue request: host sets, send-done clears; a new set wins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            enqueue_r <= hfq_pkg::CTRL_RESET;
        end else if (reg_wr && lane_lo && addr_r == hfq_pkg::TXQ_CMD_OFFSET
                     && evt.wdata[hfq_pkg::TQ_ENQUEUE_BIT]) begin
            enqueue_r <= 1'b1;
        end else if (i_tx_sent) begin
            enqueue_r <= 1'b0;
        end
    end

    // Queue write strobe carries the pointer at the time of the write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_txq_write <= hfq_pkg::CTRL_RESET;
            o_txq_word  <= '0;
        end else begin
            o_txq_write <= q_wr;
            if (q_wr) begin
                o_txq_word.ptr  <= tx_ptr_r;
                o_txq_word.be   <= be_r;
                o_txq_word.data <= evt.wdata;
            end
        end
    end

    // Register read mux; reserved bits stay zero
    always_comb begin
        reg_rdata = 16'h0000;
        unique case (addr_r)
            hfq_pkg::QUEUE_CMD_OFFSET: begin
                reg_rdata[hfq_pkg::QC_BYTE_STS_BIT]  = byte_hit_r;
                reg_rdata[hfq_pkg::QC_FRAME_STS_BIT] = frame_hit_r;
                reg_rdata[hfq_pkg::QC_BYTE_THR_BIT]  = byte_thr_en_r;
                reg_rdata[hfq_pkg::QC_FRAME_THR_BIT] = frame_thr_en_r;
                reg_rdata[hfq_pkg::QC_AUTO_DEQ_BIT]  = auto_deq_r;
                reg_rdata[hfq_pkg::QC_START_DMA_BIT] = start_dma_r;
                reg_rdata[hfq_pkg::QC_RELEASE_BIT]   = release_r;
            end
            hfq_pkg::TX_PTR_OFFSET: begin
                reg_rdata[hfq_pkg::TP_AUTO_INC_BIT]  = auto_inc_r;
                reg_rdata[hfq_pkg::TP_PTR_W-1:0]     = tx_ptr_r;
            end
            hfq_pkg::TXQ_CMD_OFFSET: begin
                reg_rdata[hfq_pkg::TQ_ENQUEUE_BIT]   = enqueue_r;
            end
            default: begin
                reg_rdata = 16'h0000;
            end
        endcase
    end

    // Read path sequencing
    always_comb begin
        rd_state_nxt = rd_state_r;
        unique case (rd_state_r)
            hfq_pkg::RD_IDLE: begin
                if (evt.rd_start && data_cycle) begin
                    rd_state_nxt = queue_path ? hfq_pkg::RD_QUEUE : hfq_pkg::RD_REG;
                end
            end
            hfq_pkg::RD_REG, hfq_pkg::RD_QUEUE: begin
                if (evt.rd_end) begin
                    rd_state_nxt = hfq_pkg::RD_IDLE;
                end
            end
            default: begin
                rd_state_nxt = hfq_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_state_r <= hfq_pkg::RD_IDLE;
        end else begin
            rd_state_r <= rd_state_nxt;
        end
    end

    // Read data and pin drive; the queue word is re-sampled each cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_data      <= hfq_pkg::DATA_RESET;
            o_data_oe_n <= 1'b1;
            o_rxq_read  <= hfq_pkg::CTRL_RESET;
        end else begin
            o_data_oe_n <= (rd_state_nxt == hfq_pkg::RD_IDLE);
            o_rxq_read  <= (rd_state_r == hfq_pkg::RD_IDLE)
                           && (rd_state_nxt == hfq_pkg::RD_QUEUE);
            if (rd_state_nxt == hfq_pkg::RD_QUEUE) begin
                o_data <= i_rxq_data;
            end else if (rd_state_nxt == hfq_pkg::RD_REG) begin
                o_data <= reg_rdata;
            end
        end
    end

    // Flag copies for the surrounding queue logic
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rx_release_req <= hfq_pkg::CTRL_RESET;
            o_tx_enqueue_req <= hfq_pkg::CTRL_RESET;
            o_start_dma      <= hfq_pkg::CTRL_RESET;
        end else begin
            o_rx_release_req <= release_r;
            o_tx_enqueue_req <= enqueue_r;
            o_start_dma      <= start_dma_r;
        end
    end

endmodule

// ---- hfq_assertions.sv ----
// Port-level assertions for the host frame queue access block
`timescale 1ns/1ps
module hfq_assertions (
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        i_chip_select_n,
    input wire logic        i_read_strobe_n,
    input wire logic        o_data_oe_n,
    input wire logic [15:0] i_rx_byte_count,
    input wire logic [15:0] i_rx_byte_threshold_value,
    input wire logic [7:0]  i_rx_frame_count,
    input wire logic [7:0]  i_rx_frame_threshold_value,
    input wire logic        o_rx_threshold_irq,
    input wire logic        i_rx_frame_read_done,
    input wire logic        o_rx_dequeue,
    input wire logic        o_rxq_read,
    input wire logic        i_rx_release_done,
    input wire logic        o_rx_release_req,
    input wire logic        o_txq_write,
    input wire logic        i_tx_sent,
    input wire logic        o_tx_enqueue_req,
    input wire logic        o_start_dma
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Any count past its threshold; irq lags by two stages, checks allow one or two
    logic over;
    assign over = (i_rx_byte_count > i_rx_byte_threshold_value)
                  || (i_rx_frame_count > i_rx_frame_threshold_value);

    irq_cause_a: assert property (o_rx_threshold_irq |-> $past(over) || $past(over, 2))
        else $error("Irq with no count over");
    irq_quiet_a: assert property ($past(!over) && $past(!over, 2) |-> !o_rx_threshold_irq)
        else $error("Irq with counts below");
    frame_dequeue_a: assert property (o_rx_dequeue |-> $past(i_rx_frame_read_done))
        else $error("Dequeue without a finished frame read");
    txq_dma_a: assert property (o_txq_write |-> o_start_dma ##1 !o_txq_write)
        else $error("Queue write not a DMA pulse");
    rxq_dma_a: assert property (o_rxq_read |-> o_start_dma ##1 !o_rxq_read)
        else $error("Queue read not a DMA pulse");
    read_oe_a: assert property ($fell(i_read_strobe_n) && !i_chip_select_n
                                |-> ##[2:5] !o_data_oe_n)
        else $error("Data pins not driven after read strobe");
    bus_idle_a: assert property (i_read_strobe_n [*6] |-> o_data_oe_n)
        else $error("Data pins driven with no read");
    release_clr_a: assert property (o_rx_release_req && i_rx_release_done
                                    |-> ##2 !o_rx_release_req)
        else $error("Release flag not cleared");
    enqueue_clr_a: assert property (o_tx_enqueue_req && i_tx_sent
                                    |-> ##2 !o_tx_enqueue_req)
        else $error("Enqueue flag not cleared");
    reset_out_a: assert property ($rose(i_nrst) |-> o_data_oe_n && !o_start_dma)
        else $error("Outputs active on first edge after reset");

    cover property (o_rx_dequeue);
    cover property (o_rxq_read);
    cover property (o_txq_write ##1 !o_txq_write);
    cover property (o_rx_release_req && i_rx_release_done);
endmodule

// ---- host_model.sv ----
// Host processor model driving the parallel bus pins
`timescale 1ns/1ps
module host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    output logic             o_chip_select_n,
    output logic             o_read_strobe_n,
    output logic             o_write_strobe_n,
    output logic             o_cmd,
    output logic [15:0]      o_data
);

    // Idle pins; released data never shows a stale value
    initial begin
        o_chip_select_n  = 1'b1;
        o_read_strobe_n  = 1'b1;
        o_write_strobe_n = 1'b1;
        o_cmd            = 1'b0;
        o_data           = 16'hFFFF;
    end

    // Pins move a fixed delay after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #5;
    endtask

    // write under chip select; data held past the rise for the commit
    task automatic wr(input logic c, input logic [15:0] d);
        tick(1);
        o_cmd            = c;
        o_data           = d;
        o_chip_select_n  = 1'b0;
        o_write_strobe_n = 1'b0;
        tick(4);
        o_write_strobe_n = 1'b1;
        tick(4);
        o_chip_select_n  = 1'b1;
        o_data           = ~d;
    endtask

    // read; answer settles three edges after the strobe falls
    task automatic rd(input logic c, output logic [15:0] d);
        tick(1);
        o_cmd           = c;
        o_chip_select_n = 1'b0;
        o_read_strobe_n = 1'b0;
        tick(5);
        d               = i_rdata;
        o_read_strobe_n = 1'b1;
        tick(4);
        o_chip_select_n = 1'b1;
    endtask
endmodule

// ---- host_frame_queue_access_test.sv ----
// Self-checking bench for the host frame queue access block
`timescale 1ns/1ps
module host_frame_queue_access_test;
    logic                i_clk;
    logic                i_nrst = 1'b0;
    logic                cs_n, rd_n, wr_n, cmd, oe_n, irq, deq, rxq_rd, rel_req, txq_wr;
    logic                enq_req, sdma;
    logic                frame_done = 1'b0, rel_done = 1'b0, tx_enq = 1'b0, tx_sent = 1'b0;
    logic [15:0]         wdata, rdata;
    logic [15:0]         rxq_data = 16'hA5C3, byte_cnt = 16'h0010, byte_thr = 16'h0010;
    logic [7:0]          frm_cnt = 8'h03, frm_thr = 8'h03;
    logic [10:0]         next_free = 11'h123;
    logic [10:0]         ptrs[$];
    hfq_pkg::txq_write_s txq_word;
    int                  n_errors = 0;
    int                  n_compared = 0;
    int                  n_deq = 0, n_rxq = 0;

    host_frame_queue_access host_frame_queue_access_i (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_chip_select_n(cs_n), .i_read_strobe_n(rd_n),
        .i_write_strobe_n(wr_n), .i_cmd(cmd), .i_data(wdata), .o_data(rdata),
        .o_data_oe_n(oe_n), .i_rx_byte_count(byte_cnt), .i_rx_byte_threshold_value(byte_thr),
        .i_rx_frame_count(frm_cnt), .i_rx_frame_threshold_value(frm_thr),
        .o_rx_threshold_irq(irq), .i_rx_frame_read_done(frame_done), .o_rx_dequeue(deq),
        .o_rxq_read(rxq_rd), .i_rxq_data(rxq_data), .i_rx_release_done(rel_done),
        .o_rx_release_req(rel_req), .o_txq_write(txq_wr), .o_txq_word(txq_word),
        .i_tx_enqueued(tx_enq), .i_tx_next_free(next_free), .i_tx_sent(tx_sent),
        .o_tx_enqueue_req(enq_req), .o_start_dma(sdma)
    );
    host_model host_model_i (
        .i_clk(i_clk), .i_rdata(rdata), .o_chip_select_n(cs_n), .o_read_strobe_n(rd_n),
        .o_write_strobe_n(wr_n), .o_cmd(cmd), .o_data(wdata)
    );

    // 20 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // Tally device pulses and queue write pointers as they pass
    always @(posedge i_clk) begin
        if (deq === 1'b1) n_deq++;
        if (rxq_rd === 1'b1) n_rxq++;
        if (txq_wr === 1'b1) ptrs.push_back(txq_word.ptr);
    end

    task automatic stop_test();
        $display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    // Address cycle with all lanes enabled, then one data cycle
    task automatic reg_wr(input logic [10:0] a, input logic [15:0] d);
        host_model_i.wr(1'b1, {4'hF, 1'b0, a});
        host_model_i.wr(1'b0, d);
    endtask
    task automatic reg_rd(input logic [10:0] a, output logic [15:0] d);
        host_model_i.wr(1'b1, {4'hF, 1'b0, a});
        host_model_i.rd(1'b0, d);
    endtask
    task automatic qc_wr(input logic [15:0] d);
        reg_wr(hfq_pkg::QUEUE_CMD_OFFSET, d);
    endtask

    // Bounded wait on a status level: 0 release, 1 enqueue, 2 irq
    task automatic wait_lvl(input int sel, input logic lvl);
        logic v;
        for (int k = 0; k < 12; k++) begin
            host_model_i.tick(1);
            v = (sel == 0) ? rel_req : (sel == 1) ? enq_req : irq;
            if (v === lvl) break;
        end
        chk({15'h0000, v}, {15'h0000, lvl});
        if (v !== lvl) stop_test();
    endtask

    task automatic t_regs();
        logic [15:0] d;
        chk({15'h0000, oe_n}, 16'h0001);
        reg_rd(hfq_pkg::TX_PTR_OFFSET, d);
        chk(d, 16'h0000);
        reg_wr(hfq_pkg::TX_PTR_OFFSET, 16'hFFFF);
        reg_rd(hfq_pkg::TX_PTR_OFFSET, d);
        chk(d, 16'h4000);
        qc_wr(16'hE106);
        reg_rd(hfq_pkg::QUEUE_CMD_OFFSET, d);
        chk(d, 16'h0000);
        $display("Test regs done");
    endtask

    // Equal counts must not fire; one more does
    task automatic t_irq();
        qc_wr(16'h0040);
        host_model_i.tick(3);
        chk({15'h0000, irq}, 16'h0000);
        byte_cnt = 16'h0011;
        wait_lvl(2, 1'b1);
        byte_thr = 16'h0011;
        wait_lvl(2, 1'b0);
        qc_wr(16'h0020);
        frm_thr = 8'h02;
        wait_lvl(2, 1'b1);
        frm_cnt = 8'h02;
        wait_lvl(2, 1'b0);
        frm_cnt = 8'h04;
        wait_lvl(2, 1'b1);
        qc_wr(16'h0000);
        wait_lvl(2, 1'b0);
        $display("Test irq done");
    endtask

    // Second pass runs with auto dequeue off and must add nothing
    task automatic t_deq();
        int n0;
        n0 = n_deq;
        qc_wr(16'h0010);
        for (int k = 0; k < 2; k++) begin
            frame_done = 1'b1;
            host_model_i.tick(1);
            frame_done = 1'b0;
            host_model_i.tick(3);
            chk(16'(n_deq - n0), 16'h0001);
            qc_wr(16'h0000);
        end
        $display("Test dequeue done");
    endtask

    task automatic t_release();
        logic [15:0] d;
        qc_wr(16'h0001);
        wait_lvl(0, 1'b1);
        rel_done = 1'b1;
        host_model_i.tick(1);
        rel_done = 1'b0;
        wait_lvl(0, 1'b0);
        reg_rd(hfq_pkg::QUEUE_CMD_OFFSET, d);
        chk(d, 16'h0000);
        reg_wr(hfq_pkg::TXQ_CMD_OFFSET, 16'h0001);
        wait_lvl(1, 1'b1);
        tx_sent = 1'b1;
        host_model_i.tick(1);
        tx_sent = 1'b0;
        wait_lvl(1, 1'b0);
        $display("Test self clear done");
    endtask

    // Dword, word and byte steps; a register write in DMA is queue data
    task automatic t_tx_auto();
        logic [15:0] d;
        logic [10:0] exp[5] = '{11'h000, 11'h004, 11'h008, 11'h00A, 11'h00B};
        ptrs.delete();
        qc_wr(16'h0008);
        chk({15'h0000, sdma}, 16'h0001);
        host_model_i.wr(1'b1, 16'hF000);
        host_model_i.wr(1'b0, 16'h1111);
        host_model_i.wr(1'b0, 16'h2222);
        host_model_i.wr(1'b1, 16'h3000);
        host_model_i.wr(1'b0, 16'h3333);
        host_model_i.wr(1'b1, 16'h1000);
        host_model_i.wr(1'b0, 16'h4444);
        reg_wr(hfq_pkg::TX_PTR_OFFSET, 16'h0000);
        host_model_i.rd(1'b0, d);
        chk(d, 16'hA5C3);
        rxq_data = 16'h5A3C;
        host_model_i.rd(1'b0, d);
        chk(d, 16'h5A3C);
        reg_rd(hfq_pkg::QUEUE_CMD_OFFSET, d);
        chk(d, 16'h0008);
        qc_wr(16'h0000);
        chk(16'(ptrs.size()), 16'h0005);
        foreach (exp[k]) begin
            chk({5'h00, ptrs[k]}, {5'h00, exp[k]});
        end
        chk(16'(n_rxq), 16'h0002);
        reg_rd(hfq_pkg::TX_PTR_OFFSET, d);
        chk(d, 16'h400F);
        $display("Test tx auto done");
    endtask

    task automatic t_tx_manual();
        logic [15:0] d;
        reg_wr(hfq_pkg::TX_PTR_OFFSET, 16'h0000);
        qc_wr(16'h0008);
        host_model_i.wr(1'b1, 16'hF000);
        host_model_i.wr(1'b0, 16'h5555);
        host_model_i.wr(1'b0, 16'h6666);
        qc_wr(16'h0000);
        chk(txq_word.data, 16'h6666);
        chk({txq_word.be, 1'b0, txq_word.ptr}, 16'hF00F);
        chk({5'h00, ptrs[6]}, 16'h000F);
        reg_rd(hfq_pkg::TX_PTR_OFFSET, d);
        chk(d, 16'h000F);
        tx_enq = 1'b1;
        host_model_i.tick(1);
        tx_enq = 1'b0;
        reg_rd(hfq_pkg::TX_PTR_OFFSET, d);
        chk(d, 16'h0123);
        $display("Test tx manual done");
    endtask

    // Reset for 8 clocks, then the scenarios in turn
    initial begin
        repeat (8) @(posedge i_clk);
        #5;
        i_nrst = 1'b1;
        host_model_i.tick(2);
        t_regs();
        t_irq();
        t_deq();
        t_release();
        t_tx_auto();
        t_tx_manual();
        stop_test();
    end
endmodule

bind host_frame_queue_access hfq_assertions hfq_assertions_i (.*);
